// >>> hdl/mac_cfg_pkg.sv
// constants for the multiply-accumulate configuration-zero control block
package mac_cfg_pkg;

  // special-function register space
  localparam int          SFR_AW              = 8;
  localparam int          SFR_DW              = 8;
  localparam logic [7:0]  MAC_CONFIG_ZERO_ADR = 8'hC0;
  localparam logic [7:0]  MAC_CONFIG_ZERO_RST = 8'h00;
  localparam logic [7:0]  SFR_UNMAPPED_DATA   = 8'h00;

  // field positions in mac_config_zero
  localparam int BIT_ACCUM_SHIFT_TRIGGER = 7;
  localparam int BIT_SHIFT_DIRECTION     = 6;
  localparam int BIT_ACCUM_CLEAR         = 5;
  localparam int BIT_FRACTIONAL_SELECT   = 4;
  localparam int BIT_MULTIPLY_ONLY       = 3;
  localparam int BIT_ACCUM_INPUT_NEGATE  = 2;
  localparam int BIT_OPERAND_B_NEGATE    = 1;
  localparam int BIT_OPERAND_A_NEGATE    = 0;

  // datapath widths
  localparam int ACC_W  = 40;
  localparam int OPND_W = 16;
  localparam int SHAMT_W = 2;

  // field encodings
  localparam logic SHIFT_DIR_LEFT    = 1'b0;
  localparam logic SHIFT_DIR_RIGHT   = 1'b1;
  localparam logic MODE_INTEGER      = 1'b0;
  localparam logic MODE_FRACTIONAL   = 1'b1;
  localparam logic MODE_MAC          = 1'b0;
  localparam logic MODE_MULT_ONLY    = 1'b1;

  // shift amount: code 00..11 means 1..4 bits
  localparam int MULTI_SHIFT_BIAS = 1;
  localparam int SINGLE_SHIFT     = 1;
  localparam int FRAC_ALIGN_SHIFT = 1;

  typedef enum logic [1:0] {
    ACT_IDLE,
    ACT_CLEAR,
    ACT_OPERATE,
    ACT_SHIFT
  } action_e;

endpackage

// >>> hdl/mac_config_zero_control.sv
// configuration-zero control and accumulator datapath of the multiply-accumulate unit
`timescale 1ns/10ps
`default_nettype none
module mac_config_zero_control #(
  parameter int ACC_WIDTH  = mac_cfg_pkg::ACC_W,
  parameter int OPND_WIDTH = mac_cfg_pkg::OPND_W
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  sys_rst_i,
  input  wire logic [mac_cfg_pkg::SFR_AW-1:0]        sfr_addr_i,
  input  wire logic [mac_cfg_pkg::SFR_DW-1:0]        sfr_wdata_i,
  input  wire logic                                  sfr_wr_i,
  input  wire logic                                  sfr_rd_i,
  input  wire logic                                  dma_mode_i,
  input  wire logic                                  signed_arith_enable_i,
  input  wire logic [mac_cfg_pkg::SHAMT_W-1:0]       multi_shift_amount_i,
  input  wire logic                                  op_start_i,
  input  wire logic [OPND_WIDTH-1:0]                 operand_a_i,
  input  wire logic [OPND_WIDTH-1:0]                 operand_b_i,
  output logic      [mac_cfg_pkg::SFR_DW-1:0]        sfr_rdata_o,
  output logic      [ACC_WIDTH-1:0]                  accum_o,
  output logic                                       status_clear_o,
  output logic                                       op_done_o,
  output logic                                       fractional_select_o,
  output logic                                       multiply_only_select_o
);
  import mac_cfg_pkg::*;

  localparam int PROD_W = 2 * (OPND_WIDTH + 1);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic                 shift_direction_q,      shift_direction_d;
  logic                 fractional_select_q,    fractional_select_d;
  logic                 multiply_only_select_q, multiply_only_select_d;
  logic                 accum_input_negate_q,   accum_input_negate_d;
  logic                 operand_b_negate_q,     operand_b_negate_d;
  logic                 operand_a_negate_q,     operand_a_negate_d;
  logic                 dma_shift_enable_q,     dma_shift_enable_d;
  logic [SFR_DW-1:0]    sfr_rdata_q,            sfr_rdata_d;

  logic                 cfg_write;
  logic                 trigger_written;
  logic                 clear_written;
  logic [ACC_WIDTH-1:0] accum_q;
  logic [ACC_WIDTH-1:0] accum_d;

  ////////////////////////////////////////////////////////////////////////////
  // write decode: one strobe per action bit

  always_comb begin
    cfg_write       = sfr_wr_i && (sfr_addr_i == MAC_CONFIG_ZERO_ADR);
    trigger_written = cfg_write && sfr_wdata_i[BIT_ACCUM_SHIFT_TRIGGER];
    clear_written   = cfg_write && sfr_wdata_i[BIT_ACCUM_CLEAR];
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored configuration bits

  always_comb begin
    // clear is a pulse with no stored copy here; the trigger is kept only as the DMA shift enable
    shift_direction_d      = shift_direction_q;
    fractional_select_d    = fractional_select_q;
    multiply_only_select_d = multiply_only_select_q;
    accum_input_negate_d   = accum_input_negate_q;
    operand_b_negate_d     = operand_b_negate_q;
    operand_a_negate_d     = operand_a_negate_q;
    dma_shift_enable_d     = dma_shift_enable_q;
    if (cfg_write) begin
      shift_direction_d      = sfr_wdata_i[BIT_SHIFT_DIRECTION];
      fractional_select_d    = sfr_wdata_i[BIT_FRACTIONAL_SELECT];
      multiply_only_select_d = sfr_wdata_i[BIT_MULTIPLY_ONLY];
      accum_input_negate_d   = sfr_wdata_i[BIT_ACCUM_INPUT_NEGATE];
      operand_b_negate_d     = sfr_wdata_i[BIT_OPERAND_B_NEGATE];
      operand_a_negate_d     = sfr_wdata_i[BIT_OPERAND_A_NEGATE];
      // the trigger doubles as a held enable only while DMA runs the unit
      dma_shift_enable_d     = trigger_written && dma_mode_i;
    end
    // leaving DMA mode drops the enable so a later run starts clean
    if (!dma_mode_i) begin
      dma_shift_enable_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      shift_direction_q      <= MAC_CONFIG_ZERO_RST[BIT_SHIFT_DIRECTION];
      fractional_select_q    <= MAC_CONFIG_ZERO_RST[BIT_FRACTIONAL_SELECT];
      multiply_only_select_q <= MAC_CONFIG_ZERO_RST[BIT_MULTIPLY_ONLY];
      accum_input_negate_q   <= MAC_CONFIG_ZERO_RST[BIT_ACCUM_INPUT_NEGATE];
      operand_b_negate_q     <= MAC_CONFIG_ZERO_RST[BIT_OPERAND_B_NEGATE];
      operand_a_negate_q     <= MAC_CONFIG_ZERO_RST[BIT_OPERAND_A_NEGATE];
      dma_shift_enable_q     <= 1'b0;
    end else begin
      shift_direction_q      <= shift_direction_d;
      fractional_select_q    <= fractional_select_d;
      multiply_only_select_q <= multiply_only_select_d;
      accum_input_negate_q   <= accum_input_negate_d;
      operand_b_negate_q     <= operand_b_negate_d;
      operand_a_negate_q     <= operand_a_negate_d;
      dma_shift_enable_q     <= dma_shift_enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back path: registered, holds until the next read

  always_comb begin
    // write-only trigger and clear read as zero
    sfr_rdata_d = sfr_rdata_q;
    if (sfr_rd_i) begin
      if (sfr_addr_i == MAC_CONFIG_ZERO_ADR) begin
        sfr_rdata_d                          = MAC_CONFIG_ZERO_RST;
        sfr_rdata_d[BIT_ACCUM_SHIFT_TRIGGER] = 1'b0;
        sfr_rdata_d[BIT_ACCUM_CLEAR]         = 1'b0;
        sfr_rdata_d[BIT_SHIFT_DIRECTION]     = shift_direction_q;
        sfr_rdata_d[BIT_FRACTIONAL_SELECT]   = fractional_select_q;
        sfr_rdata_d[BIT_MULTIPLY_ONLY]       = multiply_only_select_q;
        sfr_rdata_d[BIT_ACCUM_INPUT_NEGATE]  = accum_input_negate_q;
        sfr_rdata_d[BIT_OPERAND_B_NEGATE]    = operand_b_negate_q;
        sfr_rdata_d[BIT_OPERAND_A_NEGATE]    = operand_a_negate_q;
      end else begin
        // unmapped addresses answer a fixed byte rather than float
        sfr_rdata_d = SFR_UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sfr_rdata_q <= MAC_CONFIG_ZERO_RST;
    end else begin
      sfr_rdata_q <= sfr_rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplier path: operands are copied, never written back

  logic signed [OPND_WIDTH:0]  mul_a;
  logic signed [OPND_WIDTH:0]  mul_b;
  logic signed [PROD_W-1:0]    product;
  logic signed [ACC_WIDTH-1:0] product_ext;
  logic signed [ACC_WIDTH-1:0] accum_in;
  logic signed [ACC_WIDTH-1:0] op_result;
  logic [2:0]                  dma_shift_bits;
  logic [ACC_WIDTH-1:0]        shifted_result;

  always_comb begin
    // one extra bit keeps unsigned operands positive after extension
    mul_a = {signed_arith_enable_i & operand_a_i[OPND_WIDTH-1], operand_a_i};
    mul_b = {signed_arith_enable_i & operand_b_i[OPND_WIDTH-1], operand_b_i};
    if (operand_a_negate_q) begin
      mul_a = -mul_a;
    end
    if (operand_b_negate_q) begin
      mul_b = -mul_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // product and fractional alignment

  always_comb begin
    product     = PROD_W'(mul_a * mul_b);
    product_ext = ACC_WIDTH'(product);
    if (fractional_select_q == MODE_FRACTIONAL) begin
      product_ext = product_ext <<< FRAC_ALIGN_SHIFT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator input and sum

  always_comb begin
    // negation assumes software enabled signed mode as required
    accum_in = accum_input_negate_q ? -$signed(accum_q) : $signed(accum_q);
    if (multiply_only_select_q == MODE_MULT_ONLY) begin
      accum_in = '0;
    end
    op_result = product_ext + accum_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma end-of-operation shift

  always_comb begin
    dma_shift_bits = 3'(multi_shift_amount_i) + 3'(MULTI_SHIFT_BIAS);
    shifted_result = op_result;
    if (dma_mode_i && dma_shift_enable_q) begin
      if (shift_direction_q == SHIFT_DIR_LEFT) begin
        shifted_result = op_result << dma_shift_bits;
      end else if (signed_arith_enable_i) begin
        shifted_result = op_result >>> dma_shift_bits;
      end else begin
        shifted_result = op_result >> dma_shift_bits;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator sequencing: clear beats operate beats shift

  logic                 status_clear_q, status_clear_d;
  logic                 op_done_q, op_done_d;
  action_e              action;

  ////////////////////////////////////////////////////////////////////////////
  // action select

  // one action per cycle; the loser of a collision is simply dropped
  always_comb begin
    if (clear_written && !dma_mode_i) begin
      action = ACT_CLEAR;
    end else if (op_start_i) begin
      action = ACT_OPERATE;
    end else if (trigger_written && !dma_mode_i) begin
      action = ACT_SHIFT;
    end else begin
      action = ACT_IDLE;
    end
  end

  always_comb begin
    accum_d        = accum_q;
    status_clear_d = 1'b0;
    op_done_d      = 1'b0;
    case (action)
      ACT_CLEAR: begin
        accum_d        = '0;
        status_clear_d = 1'b1;
      end
      ACT_OPERATE: begin
        accum_d   = shifted_result;
        op_done_d = 1'b1;
      end
      ACT_SHIFT: begin
        // the direction written with the trigger steers this very shift
        if (shift_direction_d == SHIFT_DIR_LEFT) begin
          accum_d = accum_q << SINGLE_SHIFT;
        end else if (signed_arith_enable_i) begin
          // kept out of a mixed conditional, which would make the shift logical
          accum_d = $signed(accum_q) >>> SINGLE_SHIFT;
        end else begin
          accum_d = accum_q >> SINGLE_SHIFT;
        end
      end
      ACT_IDLE: begin
        accum_d = accum_q;
      end
      default: begin
        accum_d = accum_q;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      accum_q        <= '0;
      status_clear_q <= 1'b0;
      op_done_q      <= 1'b0;
    end else begin
      accum_q        <= accum_d;
      status_clear_q <= status_clear_d;
      op_done_q      <= op_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign sfr_rdata_o            = sfr_rdata_q;
  assign accum_o                = accum_q;
  assign status_clear_o         = status_clear_q;
  assign op_done_o              = op_done_q;
  assign fractional_select_o    = fractional_select_q;
  assign multiply_only_select_o = multiply_only_select_q;

endmodule
`default_nettype wire

// >>> test/mac_config_zero_asserts.sv
// port assertions for the configuration-zero control block
`timescale 1ns/10ps
`default_nettype none
module mac_config_zero_asserts
  import mac_cfg_pkg::*;
#(
  parameter int ACC_WIDTH  = ACC_W,
  parameter int OPND_WIDTH = OPND_W
) (
  input wire logic                 clk_i,
  input wire logic                 sys_rst_i,
  input wire logic [7:0]           sfr_addr_i,
  input wire logic [7:0]           sfr_wdata_i,
  input wire logic                 sfr_wr_i,
  input wire logic                 sfr_rd_i,
  input wire logic                 dma_mode_i,
  input wire logic                 signed_arith_enable_i,
  input wire logic                 op_start_i,
  input wire logic [7:0]           sfr_rdata_o,
  input wire logic [ACC_WIDTH-1:0] accum_o,
  input wire logic                 status_clear_o,
  input wire logic                 op_done_o,
  input wire logic                 fractional_select_o,
  input wire logic                 multiply_only_select_o
);
  logic [7:0] wdata_q;
  always_ff @(posedge clk_i) begin
    wdata_q <= sfr_wdata_i;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_cfg_wr;
    sfr_wr_i && sfr_addr_i == MAC_CONFIG_ZERO_ADR;
  endsequence
  // clear has priority, so a trigger only counts without it and without an operation
  sequence s_trig_mcu;
    s_cfg_wr ##0 (sfr_wdata_i[7] && !sfr_wdata_i[5] && !dma_mode_i && !op_start_i);
  endsequence
  AST_CLR_MCU: assert property (s_cfg_wr ##0 (sfr_wdata_i[5] && !dma_mode_i)
    |=> accum_o == '0 && status_clear_o) else $error("clear did not zero accumulator");
  AST_CLR_DMA: assert property (s_cfg_wr ##0 (dma_mode_i && !op_start_i)
    |=> !status_clear_o && $stable(accum_o)) else $error("write in dma mode moved state");
  AST_SHL: assert property (s_trig_mcu ##0 !sfr_wdata_i[6]
    |=> accum_o == $past(accum_o) << 1) else $error("left shift wrong");
  AST_SHR: assert property (s_trig_mcu ##0 (sfr_wdata_i[6] && !signed_arith_enable_i)
    |=> accum_o == $past(accum_o) >> 1) else $error("right shift wrong");
  AST_TRIG_ONCE: assert property (s_trig_mcu ##1 (!sfr_wr_i && !op_start_i)
    |=> $stable(accum_o)) else $error("trigger kept shifting");
  AST_RD_MASK: assert property (sfr_rd_i
    |=> !sfr_rdata_o[7] && !sfr_rdata_o[5]) else $error("write-only bit read back");
  AST_FRAC: assert property (s_cfg_wr
    |=> fractional_select_o == wdata_q[4]) else $error("fractional copy wrong");
  AST_MONLY: assert property (s_cfg_wr
    |=> multiply_only_select_o == wdata_q[3]) else $error("multiply-only copy wrong");
  AST_DONE: assert property (op_start_i && !(sfr_wr_i && sfr_wdata_i[5] && !dma_mode_i)
    |=> op_done_o) else $error("operation not done");
  AST_DONE_ONLY: assert property (!op_start_i |=> !op_done_o)
    else $error("done without start");
  AST_RST: assert property (disable iff (1'b0) sys_rst_i
    |=> !multiply_only_select_o && accum_o == '0) else $error("reset state wrong");
endmodule
bind mac_config_zero_control mac_config_zero_asserts #(.ACC_WIDTH(ACC_WIDTH),
  .OPND_WIDTH(OPND_WIDTH)) u_chk (.clk_i, .sys_rst_i, .sfr_addr_i, .sfr_wdata_i,
  .sfr_wr_i, .sfr_rd_i, .dma_mode_i, .signed_arith_enable_i, .op_start_i, .sfr_rdata_o,
  .accum_o, .status_clear_o, .op_done_o, .fractional_select_o, .multiply_only_select_o);
`default_nettype wire

// >>> test/operand_source.sv
// core-side model holding the operand registers and signed enable
`timescale 1ns/10ps
`default_nettype none
module operand_source (
  input  wire logic        clk_i,
  input  wire logic        load_i,
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  input  wire logic        signed_i,
  output logic      [15:0] operand_a_o,
  output logic      [15:0] operand_b_o,
  output logic             signed_o
);
  // operands change only on a core store, never through the unit
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      operand_a_o <= a_i;
      operand_b_o <= b_i;
      signed_o    <= signed_i;
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the configuration-zero control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic        clk_i, sys_rst_i, wr, rd, dma, op, ld, sgn_in, sgn;
  logic        sclr, done, frac, monly;
  logic [7:0]  addr, wdata, rdata;
  logic [1:0]  code;
  logic [15:0] a_in, b_in, opa, opb;
  logic [39:0] accum;
  logic [39:0] dma_exp [4] = '{40'd32, 40'd11, 40'd3, 40'd1};
  int          n_errors = 0, checks = 0, cyc = 0;
  operand_source src (.clk_i(clk_i), .load_i(ld), .a_i(a_in), .b_i(b_in), .signed_i(sgn_in),
    .operand_a_o(opa), .operand_b_o(opb), .signed_o(sgn));
  mac_config_zero_control uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .dma_mode_i(dma),
    .signed_arith_enable_i(sgn), .multi_shift_amount_i(code), .op_start_i(op),
    .operand_a_i(opa), .operand_b_i(opb), .sfr_rdata_o(rdata), .accum_o(accum),
    .status_clear_o(sclr), .op_done_o(done), .fractional_select_o(frac),
    .multiply_only_select_o(monly));
  ////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    // an idle edge between calls keeps a strobe from falling and rising in one step
    @(posedge clk_i);
    #2;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_i);
    #2 wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    #2;
    addr = a;
    rd = 1'b1;
    @(posedge clk_i);
    #2 rd = 1'b0;
    `CHK(rdata, e)
  endtask
  task automatic run_op(input logic [39:0] e);
    @(posedge clk_i);
    #2;
    op = 1'b1;
    @(posedge clk_i);
    #2 op = 1'b0;
    `CHK(done, 1'b1)
    `CHK(accum, e)
  endtask
  task automatic set_ops(input logic [15:0] a, input logic [15:0] b, input logic s);
    @(posedge clk_i);
    #2;
    a_in = a;
    b_in = b;
    sgn_in = s;
    ld = 1'b1;
    @(posedge clk_i);
    #2 ld = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // the whole sequence needs well under a hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      report_and_stop;
    end
  end
  initial begin
    {sys_rst_i, wr, rd, dma, op, ld, sgn_in, addr, wdata, code, a_in, b_in} = '0;
    sys_rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    #2 sys_rst_i = 1'b0;
    set_ops(16'h0003, 16'h0005, 1'b0);
    rd_chk(8'hC0, 8'h00);
    run_op(40'd15);
    run_op(40'd30);
    wr_reg(8'hC0, 8'hA0);
    `CHK({sclr, accum}, {1'b1, 40'd0})
    rd_chk(8'hC0, 8'h00);
    `CHK(sclr, 1'b0)
    run_op(40'd15);
    wr_reg(8'hC0, 8'h80);
    `CHK(accum, 40'd30)
    wr_reg(8'hC0, 8'h40);
    wr_reg(8'hC0, 8'hC0);
    `CHK(accum, 40'd15)
    rd_chk(8'hC0, 8'h40);
    wr_reg(8'hC0, 8'h08);
    `CHK(monly, 1'b1)
    set_ops(16'h0003, 16'h0007, 1'b0);
    run_op(40'd21);
    set_ops(16'h0003, 16'h0005, 1'b1);
    wr_reg(8'hC0, 8'h01);
    run_op(40'd6);
    wr_reg(8'hC0, 8'h02);
    run_op(40'hFFFFFFFFF7);
    `CHK({opa, opb}, {16'h0003, 16'h0005})
    wr_reg(8'hC0, 8'hC2);
    `CHK(accum, 40'hFFFFFFFFFB)
    wr_reg(8'hC0, 8'h04);
    run_op(40'd20);
    wr_reg(8'hC0, 8'h10);
    `CHK(frac, 1'b1)
    run_op(40'd50);
    dma = 1'b1;
    wr_reg(8'hC0, 8'h20);
    `CHK({sclr, accum}, {1'b0, 40'd50})
    set_ops(16'h0003, 16'h0005, 1'b0);
    wr_reg(8'hC0, 8'hC0);
    `CHK(accum, 40'd50)
    for (int k = 0; k < 4; k++) begin
      code = k[1:0];
      run_op(dma_exp[k]);
    end
    dma = 1'b0;
    wr_reg(8'h55, 8'hFF);
    rd_chk(8'h55, 8'h00);
    rd_chk(8'hC0, 8'h40);
    `CHK(accum, 40'd1)
    report_and_stop;
  end
endmodule
`default_nettype wire
